//--- rtl/ecap_crc32.v
`timescale 1ns/1ns
`include "ecap_defines.vh"
// ==========================================================
// Bit-serial CRC register
module ecap_crc32 #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] POLY = `ECAP_CRC_POLY,
    parameter [WIDTH-1:0] INIT = `ECAP_CRC_INIT
) (
    input wire clock, // Device clock
    input wire rst_b, // Sync reset, active low
    input wire init, // Reload start value
    input wire en, // Advance one bit
    input wire shift_only, // Shift out, no feedback
    input wire din, // Serial data bit
    output reg [WIDTH-1:0] crc // Current remainder
);
    wire fb;

    // Shift-only mode lets the sender stream the remainder out MSB first
    assign fb = shift_only ? 1'b0 : (crc[WIDTH-1] ^ din);

    // Remainder update
    always @(posedge clock) begin
        if (!rst_b || init) begin
            crc <= INIT;
        end else if (en) begin
            crc <= {crc[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
        end
    end
endmodule

//--- rtl/ecap_defines.vh
`ifndef ECAP_DEFINES_VH
`define ECAP_DEFINES_VH
// ==========================================================
// Timing
`define ECAP_CLK_NS 4
`define ECAP_BIT_NS 100
// ==========================================================
// Register word indices on the Avalon address
`define ECAP_REG_CONTROL 4'h0
`define ECAP_REG_THRESH 4'h1
`define ECAP_REG_PHYS_LO 4'h2
`define ECAP_REG_PHYS_HI 4'h3
`define ECAP_REG_HASH_LO 4'h4
`define ECAP_REG_HASH_HI 4'h5
`define ECAP_REG_MODE 4'h6
`define ECAP_REG_STATUS 4'h7
// ==========================================================
// Fields and reset values
`define ECAP_PAD_BIT 11
`define ECAP_STRIP_BIT 10
`define ECAP_MODE_PROM_BIT 0
`define ECAP_MODE_NOBC_BIT 1
`define ECAP_CTRL_RESET 32'h00000c00
`define ECAP_THRESH_RESET 32'h00000040
`define ECAP_MODE_RESET 32'h00000000
// ==========================================================
// Framing constants, patterns in transmission order
`define ECAP_PREAMBLE 8'haa
`define ECAP_SFD 8'hab
`define ECAP_PRE_LAST 11'h006
`define ECAP_SKIP_LAST 3'h7
`define ECAP_BYTE_LAST 5'h07
`define ECAP_FCS_LAST 5'h1f
`define ECAP_MIN_FRAME 11'h040
`define ECAP_MIN_NOFCS 11'h03c
`define ECAP_MIN_DATA 16'h002e
`define ECAP_HDR_BYTES 11'h00e
`define ECAP_DA_LAST 11'h005
`define ECAP_DECIDE 11'h006
`define ECAP_LEN_HI 11'h00c
`define ECAP_LEN_LO 11'h00d
`define ECAP_BCAST 48'hffffffffffff
// ==========================================================
// Frame check sequence
`define ECAP_CRC_POLY 32'h04c11db7
`define ECAP_CRC_INIT 32'hffffffff
`define ECAP_CRC_RESIDUE 32'hc704dd7b
`endif

//--- rtl/ecap_frame_engine.v
`timescale 1ns/1ns
`include "ecap_defines.vh"
module ecap_frame_engine #(
    parameter LEVEL_W = 8
) (
    input wire clock, // 250 MHz device clock
    input wire rst_b, // Sync reset, active low
    input wire [3:0] avs_address, // Word index
    input wire avs_read, // Read request
    input wire avs_write, // Write request
    input wire [31:0] avs_writedata, // Write data
    output reg [31:0] avs_readdata, // Read data
    output reg avs_waitrequest, // Stall, high by default
    input wire [7:0] tx_data, // Transmit FIFO byte
    input wire tx_valid, // Transmit byte present
    input wire tx_last, // Byte ends the frame
    input wire [LEVEL_W-1:0] tx_fifo_level, // Transmit FIFO fill
    output reg tx_ready, // Byte taken when valid too
    input wire channel_free, // Deferral allows access
    output reg tx_out, // Serial bit to codec
    output reg tx_en, // Transmit active
    input wire rx_bit, // Decoded bit from codec
    input wire rx_bit_strobe, // Decoded bit present
    input wire rx_carrier, // Receive activity
    input wire rx_collision, // Collision seen
    output reg [7:0] rx_out_data, // Byte to receive FIFO
    output reg rx_out_valid, // Byte pulse
    output reg rx_out_end, // End of frame pulse
    output reg rx_out_drop, // Delete frame from FIFO
    output reg rx_out_fcs_err, // FCS mismatch at end
    output reg [7:0] ext_addr_data, // Destination byte out
    output reg ext_addr_strobe, // Destination byte pulse
    input wire ext_addr_match // External filter hit
);
    localparam [31:0] BIT_CYCLES = (`ECAP_BIT_NS + `ECAP_CLK_NS - 1) /
                                   `ECAP_CLK_NS;
    localparam [4:0] BIT_LAST = BIT_CYCLES[4:0] - 5'h01;
    localparam [31:0] THRESH_INIT = `ECAP_THRESH_RESET;
    localparam [31:0] MODE_INIT = `ECAP_MODE_RESET;
    localparam [5:0] T_IDLE = 6'h01;
    localparam [5:0] T_PRE = 6'h02;
    localparam [5:0] T_SFD = 6'h04;
    localparam [5:0] T_DATA = 6'h08;
    localparam [5:0] T_PAD = 6'h10;
    localparam [5:0] T_FCS = 6'h20;
    localparam [4:0] R_IDLE = 5'h01;
    localparam [4:0] R_SKIP = 5'h02;
    localparam [4:0] R_HUNT = 5'h04;
    localparam [4:0] R_FRAME = 5'h08;
    localparam [4:0] R_WAIT = 5'h10;

    reg [31:0] control;
    reg [LEVEL_W-1:0] thresh;
    reg [47:0] phys;
    reg [63:0] hash;
    reg [1:0] mode;
    reg [7:0] runt_count;
    reg [7:0] good_count;
    reg [31:0] next_readdata;
    reg [4:0] bit_div;
    reg bit_en;
    reg [5:0] tx_state;
    reg [7:0] tx_sr;
    reg [4:0] tx_bitcnt;
    reg [10:0] tx_bytecnt;
    reg [7:0] hold;
    reg hold_full;
    reg hold_last;
    reg got_last;
    reg cur_last;
    reg tx_corrupt;
    reg [4:0] rx_state;
    reg [2:0] rx_bitcnt;
    reg [7:0] rx_sr;
    reg [10:0] rx_count;
    reg [47:0] da;
    reg [7:0] len_hi;
    reg strip_on;
    reg [10:0] strip_limit;
    reg accepted;
    reg [5:0] hash_idx;
    reg byte_done_d;
    reg fcs_good;
    reg ext_match_m;
    reg ext_match_s;
    wire [31:0] tx_crc;
    wire [31:0] rx_crc;
    wire [10:0] tx_next_count;
    wire [7:0] rx_byte;
    wire [15:0] rx_len;
    wire fetch_ok;
    wire tx_start;
    wire crc_tx_en;
    wire pad_en;
    wire strip_en;

    assign pad_en = control[`ECAP_PAD_BIT];
    assign strip_en = control[`ECAP_STRIP_BIT];
    assign tx_next_count = tx_bytecnt + 11'h001;
    assign rx_byte = {rx_bit, rx_sr[7:1]};
    assign rx_len = {len_hi, rx_byte};
    assign fetch_ok = ((tx_state & (T_PRE | T_SFD | T_DATA)) != 6'h00)
                      && !got_last;
    // Deferral outside decides availability; half duplex only
    assign tx_start = tx_valid && (tx_fifo_level >= thresh)
                      && channel_free;
    assign crc_tx_en = bit_en && ((tx_state & (T_DATA | T_PAD | T_FCS))
                       != 6'h00);

    // ==========================================================
    // CRC engines
    ecap_crc32 u_tx_crc (
        .clock(clock),
        .rst_b(rst_b),
        .init(tx_state == T_IDLE),
        .en(crc_tx_en),
        .shift_only(tx_state == T_FCS),
        .din(tx_sr[7]),
        .crc(tx_crc)
    );
    ecap_crc32 u_rx_crc (
        .clock(clock),
        .rst_b(rst_b),
        .init(rx_state != R_FRAME),
        .en(rx_bit_strobe && (rx_state == R_FRAME)),
        .shift_only(1'b0),
        .din(rx_bit),
        .crc(rx_crc)
    );

    // ==========================================================
    // Avalon slave: one wait cycle, write lands when wait is low
    always @* begin
        next_readdata = 32'h00000000;
        if (avs_address == `ECAP_REG_CONTROL) begin
            next_readdata = control;
        end else if (avs_address == `ECAP_REG_THRESH) begin
            next_readdata[LEVEL_W-1:0] = thresh;
        end else if (avs_address == `ECAP_REG_PHYS_LO) begin
            next_readdata = phys[31:0];
        end else if (avs_address == `ECAP_REG_PHYS_HI) begin
            next_readdata[15:0] = phys[47:32];
        end else if (avs_address == `ECAP_REG_HASH_LO) begin
            next_readdata = hash[31:0];
        end else if (avs_address == `ECAP_REG_HASH_HI) begin
            next_readdata = hash[63:32];
        end else if (avs_address == `ECAP_REG_MODE) begin
            next_readdata[1:0] = mode;
        end else if (avs_address == `ECAP_REG_STATUS) begin
            next_readdata = {runt_count, good_count, 14'h0000,
                             rx_state == R_FRAME, tx_state != T_IDLE};
        end
    end

    // Register file and handshake
    always @(posedge clock) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            control <= `ECAP_CTRL_RESET;
            thresh <= THRESH_INIT[LEVEL_W-1:0];
            phys <= 48'h000000000000;
            hash <= 64'h0000000000000000;
            mode <= MODE_INIT[1:0];
        end else begin
            avs_waitrequest <= !((avs_read || avs_write)
                                 && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
            if (avs_write && !avs_waitrequest) begin
                if (avs_address == `ECAP_REG_CONTROL) begin
                    control <= avs_writedata;
                end else if (avs_address == `ECAP_REG_THRESH) begin
                    thresh <= avs_writedata[LEVEL_W-1:0];
                end else if (avs_address == `ECAP_REG_PHYS_LO) begin
                    phys[31:0] <= avs_writedata;
                end else if (avs_address == `ECAP_REG_PHYS_HI) begin
                    phys[47:32] <= avs_writedata[15:0];
                end else if (avs_address == `ECAP_REG_HASH_LO) begin
                    hash[31:0] <= avs_writedata;
                end else if (avs_address == `ECAP_REG_HASH_HI) begin
                    hash[63:32] <= avs_writedata;
                end else if (avs_address == `ECAP_REG_MODE) begin
                    mode <= avs_writedata[1:0];
                end
            end
        end
    end

    // ==========================================================
    // Bit-time divider, one enable per 100 ns bit
    always @(posedge clock) begin
        if (!rst_b) begin
            bit_div <= 5'h00;
            bit_en <= 1'b0;
        end else begin
            bit_en <= (bit_div == BIT_LAST);
            bit_div <= (bit_div == BIT_LAST) ? 5'h00 : bit_div + 5'h01;
        end
    end

    // ==========================================================
    // Transmit framer; one-byte holding stage fed from the FIFO.
    // Underflow sends the true remainder, so the FCS is invalid.
    always @(posedge clock) begin
        if (!rst_b) begin
            tx_state <= T_IDLE;
            tx_sr <= 8'h00;
            tx_bitcnt <= 5'h00;
            tx_bytecnt <= 11'h000;
            tx_out <= 1'b0;
            tx_en <= 1'b0;
            tx_ready <= 1'b0;
            hold <= 8'h00;
            hold_full <= 1'b0;
            hold_last <= 1'b0;
            got_last <= 1'b0;
            cur_last <= 1'b0;
            tx_corrupt <= 1'b0;
        end else begin
            tx_ready <= fetch_ok && !hold_full && !(tx_ready && tx_valid);
            if (tx_ready && tx_valid) begin
                hold <= tx_data;
                hold_last <= tx_last;
                hold_full <= 1'b1;
                got_last <= tx_last;
            end
            if (bit_en) begin
                case (tx_state)
                    T_IDLE: begin
                        tx_en <= 1'b0;
                        tx_out <= 1'b0;
                        got_last <= 1'b0;
                        if (tx_start) begin
                            tx_state <= T_PRE;
                            tx_sr <= `ECAP_PREAMBLE;
                            tx_bitcnt <= 5'h00;
                            tx_bytecnt <= 11'h000;
                            tx_corrupt <= 1'b0;
                            cur_last <= 1'b0;
                        end
                    end
                    default: begin
                        tx_en <= 1'b1;
                        if (tx_state == T_FCS) begin
                            tx_out <= tx_corrupt ? tx_crc[31] : ~tx_crc[31];
                        end else begin
                            tx_out <= tx_sr[7];
                        end
                        tx_sr <= {tx_sr[6:0], 1'b0};
                        tx_bitcnt <= tx_bitcnt + 5'h01;
                        if (tx_state == T_FCS) begin
                            if (tx_bitcnt == `ECAP_FCS_LAST) begin
                                tx_state <= T_IDLE;
                            end
                        end else if (tx_bitcnt == `ECAP_BYTE_LAST) begin
                            tx_bitcnt <= 5'h00;
                            tx_bytecnt <= tx_next_count;
                            if (tx_state == T_PRE) begin
                                if (tx_bytecnt == `ECAP_PRE_LAST) begin
                                    tx_state <= T_SFD;
                                    tx_sr <= `ECAP_SFD;
                                end else begin
                                    tx_sr <= `ECAP_PREAMBLE;
                                end
                            end else if ((tx_state == T_SFD) ||
                                         ((tx_state == T_DATA) &&
                                          !cur_last)) begin
                                if (tx_state == T_SFD) begin
                                    tx_bytecnt <= 11'h000;
                                end
                                if (hold_full) begin
                                    // LSB first on the wire
                                    tx_state <= T_DATA;
                                    tx_sr <= {hold[0], hold[1], hold[2],
                                              hold[3], hold[4], hold[5],
                                              hold[6], hold[7]};
                                    cur_last <= hold_last;
                                    hold_full <= 1'b0;
                                end else begin
                                    tx_state <= T_FCS;
                                    tx_corrupt <= 1'b1;
                                end
                            end else if (pad_en && (tx_next_count <
                                         `ECAP_MIN_NOFCS)) begin
                                tx_state <= T_PAD;
                                tx_sr <= 8'h00;
                            end else begin
                                tx_state <= T_FCS;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // External match is asynchronous to us, so resync it first
    always @(posedge clock) begin
        if (!rst_b) begin
            ext_match_m <= 1'b0;
            ext_match_s <= 1'b0;
        end else begin
            ext_match_m <= ext_addr_match;
            ext_match_s <= ext_match_m;
        end
    end

    // ==========================================================
    // Receive deframer. Bytes flow out as they arrive; rejection
    // and runt deletion are signalled at the end pulse.
    always @(posedge clock) begin
        if (!rst_b) begin
            rx_state <= R_IDLE;
            rx_bitcnt <= 3'h0;
            rx_sr <= 8'h00;
            rx_count <= 11'h000;
            da <= 48'h000000000000;
            len_hi <= 8'h00;
            strip_on <= 1'b0;
            strip_limit <= 11'h000;
            accepted <= 1'b0;
            hash_idx <= 6'h00;
            byte_done_d <= 1'b0;
            fcs_good <= 1'b0;
            rx_out_data <= 8'h00;
            rx_out_valid <= 1'b0;
            rx_out_end <= 1'b0;
            rx_out_drop <= 1'b0;
            rx_out_fcs_err <= 1'b0;
            ext_addr_data <= 8'h00;
            ext_addr_strobe <= 1'b0;
            runt_count <= 8'h00;
            good_count <= 8'h00;
        end else begin
            rx_out_valid <= 1'b0;
            rx_out_end <= 1'b0;
            ext_addr_strobe <= 1'b0;
            byte_done_d <= 1'b0;
            // Remainder sampled only on byte boundaries: dribble ignored
            if (byte_done_d) begin
                fcs_good <= (rx_crc == `ECAP_CRC_RESIDUE);
                if (rx_count == `ECAP_DECIDE) begin
                    hash_idx <= rx_crc[31:26];
                end
            end
            case (rx_state)
                R_IDLE: begin
                    rx_bitcnt <= 3'h0;
                    if (rx_carrier) begin
                        rx_state <= R_SKIP;
                    end
                end
                R_SKIP: begin
                    if (!rx_carrier) begin
                        rx_state <= R_IDLE;
                    end else if (rx_bit_strobe) begin
                        rx_bitcnt <= rx_bitcnt + 3'h1;
                        if (rx_bitcnt == `ECAP_SKIP_LAST) begin
                            rx_state <= R_HUNT;
                            rx_sr <= 8'h00;
                        end
                    end
                end
                R_HUNT: begin
                    if (!rx_carrier) begin
                        rx_state <= R_IDLE;
                    end else if (rx_collision) begin
                        rx_state <= R_WAIT;
                    end else if (rx_bit_strobe) begin
                        rx_sr <= {rx_sr[6:0], rx_bit};
                        if ({rx_sr[6:0], rx_bit} == `ECAP_SFD) begin
                            rx_state <= R_FRAME;
                            rx_bitcnt <= 3'h0;
                            rx_count <= 11'h000;
                            strip_on <= 1'b0;
                            accepted <= 1'b0;
                            fcs_good <= 1'b0;
                        end
                    end
                end
                R_FRAME: begin
                    if (!rx_carrier || rx_collision) begin
                        rx_state <= rx_carrier ? R_WAIT : R_IDLE;
                        rx_out_end <= 1'b1;
                        rx_out_drop <= (rx_count < `ECAP_MIN_FRAME)
                                       || !accepted;
                        rx_out_fcs_err <= !fcs_good;
                        if (rx_count < `ECAP_MIN_FRAME) begin
                            runt_count <= runt_count + 8'h01;
                        end else if (accepted && fcs_good) begin
                            good_count <= good_count + 8'h01;
                        end
                    end else if (rx_bit_strobe) begin
                        rx_sr <= rx_byte;
                        rx_bitcnt <= rx_bitcnt + 3'h1;
                        if (rx_bitcnt == 3'h7) begin
                            byte_done_d <= 1'b1;
                            rx_count <= rx_count + 11'h001;
                            if (rx_count <= `ECAP_DA_LAST) begin
                                da <= {rx_byte, da[47:8]};
                                ext_addr_data <= rx_byte;
                                ext_addr_strobe <= 1'b1;
                            end
                            // Decide after the full address
                            if (rx_count == `ECAP_DECIDE) begin
                                accepted <= mode[`ECAP_MODE_PROM_BIT] ||
                                    (da == phys) || ext_match_s ||
                                    ((da == `ECAP_BCAST) &&
                                     !mode[`ECAP_MODE_NOBC_BIT]) ||
                                    (da[0] && hash[hash_idx]);
                            end
                            if (rx_count == `ECAP_LEN_HI) begin
                                len_hi <= rx_byte;
                            end
                            // Length 46+ is taken as is, never checked
                            if ((rx_count == `ECAP_LEN_LO) && strip_en
                                && (rx_len < `ECAP_MIN_DATA)) begin
                                strip_on <= 1'b1;
                                strip_limit <= `ECAP_HDR_BYTES +
                                               {5'h00, rx_byte[5:0]};
                            end
                            // Stripping cuts pad and FCS together
                            if (!(strip_on &&
                                  (rx_count >= strip_limit))) begin
                                rx_out_data <= rx_byte;
                                rx_out_valid <= 1'b1;
                            end
                        end
                    end
                end
                R_WAIT: begin
                    if (!rx_carrier) begin
                        rx_state <= R_IDLE;
                    end
                end
                default: begin
                    rx_state <= R_IDLE;
                end
            endcase
        end
    end
endmodule

//--- sim/ecap_medium.sv
`timescale 1ns/1ns
// ==========================================
// Codec and wire looped back: own frame is received
module ecap_medium (
    input wire clock, // Device clock
    input wire tx_out, // Bit from engine
    input wire tx_en, // Engine sending
    output logic rx_bit = 1'b0, // Decoded bit
    output logic rx_bit_strobe = 1'b0, // Bit present
    output logic rx_carrier = 1'b0 // Wire busy
);
    logic [4:0] ph = 5'h00;
    // Mid-bit sampling keeps clear of bit edges; data toggles off strobe
    always @(posedge clock) begin
        ph <= (tx_en && ph != 5'h18) ? ph + 5'h01 : 5'h00;
        rx_bit_strobe <= tx_en && ph == 5'h0c;
        rx_carrier <= tx_en;
        rx_bit <= (tx_en && ph == 5'h0c) ? tx_out : ~rx_bit;
    end
endmodule

//--- sim/ecap_monitor.sv
`timescale 1ns/1ns
// ==========================================
// Framing checker on the engine ports
module ecap_monitor (
    input wire clock, rst_b, tx_ready, tx_valid, tx_last, tx_en, tx_out,
    input wire rx_bit_strobe, rx_carrier, rx_out_valid, rx_out_end,
    input wire rx_out_drop, ext_addr_strobe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Wire timing, 25 clocks a bit
    first_bit_a: assert property ($rose(tx_en) |-> tx_out ##25 !tx_out)
        else $error("bad first bits");
    bit_hold_a: assert property (tx_en && $changed(tx_out) |=>
        $stable(tx_out)[*8]) else $error("bit too short");
    fetch_stop_a: assert property (tx_ready && tx_valid && tx_last |=>
        !tx_ready[*8]) else $error("fetch after last");
    // Receive side follows decoded bits
    rx_valid_a: assert property (rx_out_valid |-> $past(rx_bit_strobe))
        else $error("byte without bit");
    da_strobe_a: assert property (ext_addr_strobe |-> rx_carrier)
        else $error("address byte off frame");
    end_after_a: assert property ($fell(rx_carrier) |-> ##[0:2] rx_out_end)
        else $error("no frame end");
    drop_hold_a: assert property (!rx_out_end |-> $stable(rx_out_drop))
        else $error("drop moved");
    end_pulse_a: assert property (rx_out_end |=> !rx_out_end)
        else $error("end too long");
    cover property ($rose(tx_en));
    cover property (rx_out_end && rx_out_drop);
    cover property (rx_out_end && !rx_out_drop);
endmodule
bind ecap_frame_engine ecap_monitor u_mon (.clock(clock), .rst_b(rst_b),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_en(tx_en), .tx_out(tx_out), .rx_bit_strobe(rx_bit_strobe),
    .rx_carrier(rx_carrier), .rx_out_valid(rx_out_valid),
    .rx_out_end(rx_out_end), .rx_out_drop(rx_out_drop),
    .ext_addr_strobe(ext_addr_strobe));

//--- sim/testbench.sv
`timescale 1ns/1ns
// ==========================================
// Loopback bench for the framing engine
module testbench;
    logic clock = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic tx_valid = 1'b0, tx_last = 1'b0, channel_free = 1'b1, ext_hit = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, q;
    logic [7:0] tx_data = 8'h00, tx_fifo_level = 8'h3f, frm [0:63], got [0:127];
    wire [31:0] avs_readdata;
    wire [7:0] rx_out_data, ext_addr_data;
    wire avs_waitrequest, tx_ready, tx_out, tx_en, rx_bit, rx_bit_strobe;
    wire rx_carrier, rx_out_valid, rx_out_end, rx_out_drop, rx_out_fcs_err;
    wire ext_addr_strobe;
    int err_count = 0, comparisons = 0, cyc = 0, nrx = 0, n_end = 0;
    ecap_frame_engine u_dut (.clock(clock), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .tx_fifo_level(tx_fifo_level), .channel_free(channel_free),
        .tx_out(tx_out), .tx_en(tx_en), .rx_bit(rx_bit),
        .rx_bit_strobe(rx_bit_strobe), .rx_carrier(rx_carrier),
        .rx_collision(1'b0), .rx_out_data(rx_out_data),
        .rx_out_valid(rx_out_valid), .rx_out_end(rx_out_end),
        .rx_out_drop(rx_out_drop), .rx_out_fcs_err(rx_out_fcs_err),
        .ext_addr_data(ext_addr_data), .ext_addr_strobe(ext_addr_strobe),
        .ext_addr_match(ext_hit));
    ecap_medium u_med (.clock(clock), .tx_out(tx_out), .tx_en(tx_en),
        .rx_bit(rx_bit), .rx_bit_strobe(rx_bit_strobe), .rx_carrier(rx_carrier));
    // Clock and hang guard
    always #2 clock = ~clock;
    always @(posedge clock) if (++cyc == 80000) begin
        err_count++;
        complete_run();
    end
    // Collect received bytes
    always @(posedge clock) begin
        if (rx_out_valid === 1'b1) got[nrx++] = rx_out_data;
        if (rx_out_end === 1'b1) n_end++;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Host builds DA, SA, length itself; engine adds the rest
    task frame(input int n, input logic [7:0] len, input logic [31:0] ctl);
        int i;
        bus(1'b1, 4'h0, ctl);
        for (i = 0; i < 64; i++) frm[i] = (i == 13) ? len : i[7:0];
        frm[12] = 8'h00;
        {i, nrx, n_end} = 0;
        tx_valid <= 1'b1;
        tx_data <= frm[0];
        while (i < n) begin
            @(posedge clock);
            if (tx_ready === 1'b1) i++;
            tx_data <= frm[i];
            tx_last <= (i == n - 1);
            tx_valid <= (i < n);
        end
        while (n_end == 0) @(posedge clock);
    endtask
    task regs();
        bus(1'b0, 4'h0, 32'h0);
        check(q, 32'h00000c00);
        bus(1'b0, 4'h1, 32'h0);
        check(q, 32'h00000040);
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h2, 32'h03020100);
        bus(1'b1, 4'h3, 32'h00000504);
        tx_valid <= 1'b1;
        repeat (60) @(posedge clock);
        check(tx_en, 1'b0);
        tx_fifo_level <= 8'h40;
        channel_free <= 1'b0;
        repeat (60) @(posedge clock);
        check(tx_en, 1'b0);
        channel_free <= 1'b1;
        tx_valid <= 1'b0;
        $display("regs done");
    endtask
    task pad_strip();
        int i;
        frame(16, 8'h02, 32'h00000c00);
        check(nrx, 16);
        check({rx_out_drop, rx_out_fcs_err}, 2'b00);
        for (i = 0; i < 16; i++) check(got[i], frm[i]);
        check(ext_addr_data, 8'h05);
        $display("pad_strip done");
    endtask
    task runt();
        frame(16, 8'h02, 32'h0);
        check(rx_out_drop, 1'b1);
        $display("runt done");
    endtask
    task pad_only();
        frame(16, 8'h02, 32'h00000800);
        check(nrx, 64);
        check({got[15], got[16], got[59]}, 24'h0f0000);
        check({rx_out_drop, rx_out_fcs_err}, 2'b00);
        $display("pad_only done");
    endtask
    task long_len();
        bus(1'b1, 4'h2, 32'h0);
        ext_hit <= 1'b1;
        frame(60, 8'h2e, 32'h00000c00);
        check(nrx, 64);
        check(got[40], 8'h28);
        check(rx_out_drop, 1'b0);
        bus(1'b0, 4'h7, 32'h0);
        check(q, 32'h01030000);
        $display("long_len done");
    endtask
    task complete_run();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        regs();
        pad_strip();
        runt();
        pad_only();
        long_len();
        complete_run();
    end
endmodule
